/* File: hdl/ebhw_ctl.sv */
// Behaviour
// - Assert hold grant while in hold state
// - Output-disable low floats grant, progress, fetch; under reset they stay driven
// - Hold grant high during reset
// - Progress low at first software wait, only with two or more waits
// - Progress high at last software wait
// - Progress tied to ready adds one wait
// - Fetch indicator low during instruction address
// - Ready low: wait one cycle, resample
// - Hold floats strobes, read/write, space selects
`timescale 1ns/1ps
`default_nettype none
module ebhw_ctl
  import ebhw_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic HOLD_REQ_N,
  input wire logic OUT_DISABLE_N,
  input wire logic READY,
  input wire logic ACC_START,
  input wire logic ACC_IS_FETCH,
  input wire logic ACC_IS_IO,
  input wire logic ACC_WRITE,
  input wire logic [WS_W-1:0] SW_WAIT_CNT,
  output logic ACC_DONE,
  output logic HOLD_GRANT_OUT,
  output logic HOLD_GRANT_OE,
  output logic WAIT_STATES_DONE_OUT,
  output logic WAIT_STATES_DONE_OE,
  output logic INSTR_FETCH_IND,
  output logic INSTR_FETCH_OE,
  output logic MEM_STROBE_OUT,
  output logic IO_STROBE_OUT,
  output logic RW_OUT,
  output logic BUS_CTL_OE
);
  typedef struct packed {
    ebhw_state_t st;
    logic [WS_W-1:0] ws;
    logic [WS_W-1:0] ws_tot;
    logic fetch;
    logic io;
    logic wr;
    logic done;
    logic grant;
    logic prog;
    logic fetch_ind;
    logic mem_stb;
    logic io_stb;
    logic rw;
    logic pin_oe;
    logic bus_oe;
  } ebhw_regs_t;

  ebhw_regs_t r_q, r_d;

  // Ready sampling only matters with enough programmed wait states
  function automatic logic ws_active(input logic [WS_W-1:0] n);
    return n >= WS_MIN_ACTIVE;
  endfunction : ws_active

  // Cycles in which address and strobes of an access are out
  function automatic logic in_access(input ebhw_state_t s);
    return s == EBHW_SWWAIT || s == EBHW_READY || s == EBHW_DONE;
  endfunction : in_access

  // Next state of the whole bus controller
  always_comb begin
    r_d = r_q;
    r_d.done = 1'h0;
    r_d.pin_oe = OUT_DISABLE_N;
    case (r_q.st)
      EBHW_IDLE: begin
        if (!HOLD_REQ_N) begin
          r_d.st = EBHW_HOLD;
        end else if (ACC_START) begin
          r_d.fetch = ACC_IS_FETCH;
          r_d.io = ACC_IS_IO;
          r_d.wr = ACC_WRITE;
          r_d.ws_tot = SW_WAIT_CNT;
          r_d.ws = SW_WAIT_CNT;
          if (SW_WAIT_CNT == WS_ZERO) begin
            r_d.st = EBHW_DONE;
          end else begin
            r_d.st = EBHW_SWWAIT;
            if (ws_active(SW_WAIT_CNT)) begin
              r_d.prog = PIN_ACTIVE;
            end
          end
        end
      end
      EBHW_SWWAIT: begin
        r_d.ws = r_q.ws - WS_ONE;
        // Entering last wait raises progress again
        if (r_q.ws == WS_MIN_ACTIVE) begin
          r_d.prog = PIN_IDLE;
        end
        if (r_q.ws == WS_ONE) begin
          r_d.st = ws_active(r_q.ws_tot) ? EBHW_READY : EBHW_DONE;
        end
      end
      EBHW_READY: begin
        // Low ready costs one cycle then it is looked at again
        if (READY) begin
          r_d.st = EBHW_DONE;
        end
      end
      EBHW_DONE: begin
        r_d.done = 1'h1;
        r_d.st = EBHW_IDLE;
      end
      EBHW_HOLD: begin
        if (HOLD_REQ_N) begin
          r_d.st = EBHW_IDLE;
        end
      end
      default: r_d.st = EBHW_IDLE;
    endcase
    // Registered pin levels follow the next state
    r_d.grant = (r_d.st == EBHW_HOLD) ? PIN_ACTIVE : PIN_IDLE;
    // Bus enable kept as its own flop so the pin needs no gate behind it
    r_d.bus_oe = OUT_DISABLE_N && (r_d.st != EBHW_HOLD);
    if (in_access(r_d.st)) begin
      r_d.fetch_ind = r_d.fetch ? PIN_ACTIVE : PIN_IDLE;
      r_d.mem_stb = r_d.io ? PIN_IDLE : PIN_ACTIVE;
      r_d.io_stb = r_d.io ? PIN_ACTIVE : PIN_IDLE;
      r_d.rw = ~r_d.wr;
    end else begin
      r_d.fetch_ind = PIN_IDLE;
      r_d.mem_stb = PIN_IDLE;
      r_d.io_stb = PIN_IDLE;
      r_d.rw = PIN_IDLE;
      r_d.prog = PIN_IDLE;
    end
  end

  // Constants only under reset; grant idles high
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      r_q <= '{st: EBHW_IDLE, ws: WS_ZERO, ws_tot: WS_ZERO, fetch: 1'h0, io: 1'h0, wr: 1'h0,
               done: 1'h0, grant: PIN_IDLE, prog: PIN_IDLE, fetch_ind: PIN_IDLE, mem_stb: PIN_IDLE,
               io_stb: PIN_IDLE, rw: PIN_IDLE, pin_oe: 1'h1, bus_oe: 1'h1};
    end else begin
      r_q <= r_d;
    end
  end

  // Levels and enables both leave straight from registers
  ebhw_outen u_grant (.level(r_q.grant), .oe_in(r_q.pin_oe), .pin_o(HOLD_GRANT_OUT),
                      .pin_oe(HOLD_GRANT_OE));
  ebhw_outen u_prog (.level(r_q.prog), .oe_in(r_q.pin_oe), .pin_o(WAIT_STATES_DONE_OUT),
                     .pin_oe(WAIT_STATES_DONE_OE));
  ebhw_outen u_fetch (.level(r_q.fetch_ind), .oe_in(r_q.pin_oe), .pin_o(INSTR_FETCH_IND),
                      .pin_oe(INSTR_FETCH_OE));
  ebhw_outen u_bus (.level(1'h0), .oe_in(r_q.bus_oe), .pin_o(), .pin_oe(BUS_CTL_OE));
  assign MEM_STROBE_OUT = r_q.mem_stb;
  assign IO_STROBE_OUT = r_q.io_stb;
  assign RW_OUT = r_q.rw;
  assign ACC_DONE = r_q.done;

  // Hold handshake: grant follows request, floats the bus, ends on release
  AST_GRANT_IN_HOLD: assert property (@(posedge REF_CLK) disable iff (RST)
    !HOLD_REQ_N && r_q.st == EBHW_IDLE |=> HOLD_GRANT_OUT == PIN_ACTIVE)
    else $error("grant missing after hold request");
  AST_HOLD_FLOAT: assert property (@(posedge REF_CLK) disable iff (RST)
    HOLD_GRANT_OUT == PIN_ACTIVE |-> !BUS_CTL_OE)
    else $error("bus driven in hold");
  AST_HOLD_KEEP: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_HOLD && !HOLD_REQ_N |=> HOLD_GRANT_OUT == PIN_ACTIVE)
    else $error("grant dropped early");
  AST_GRANT_DROP: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_HOLD && HOLD_REQ_N && OUT_DISABLE_N |=> HOLD_GRANT_OUT == PIN_IDLE && BUS_CTL_OE)
    else $error("grant kept after request withdrawn");

  // Output disable acts one registered cycle later, both ways
  AST_OFF_FLOATS: assert property (@(posedge REF_CLK) disable iff (RST)
    !OUT_DISABLE_N |=> !HOLD_GRANT_OE && !WAIT_STATES_DONE_OE && !INSTR_FETCH_OE && !BUS_CTL_OE)
    else $error("outputs driven while disabled");
  AST_ON_DRIVES: assert property (@(posedge REF_CLK) disable iff (RST)
    OUT_DISABLE_N |=> HOLD_GRANT_OE && WAIT_STATES_DONE_OE && INSTR_FETCH_OE)
    else $error("outputs floating while enabled");
  AST_RESET_GRANT: assert property (@(posedge REF_CLK) RST |-> HOLD_GRANT_OUT == PIN_IDLE)
    else $error("grant not high in reset");

  // Progress pin frames the software wait states, only for two or more
  AST_PROG_FALL: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_IDLE && HOLD_REQ_N && ACC_START && SW_WAIT_CNT >= WS_MIN_ACTIVE
    |=> WAIT_STATES_DONE_OUT == PIN_ACTIVE)
    else $error("progress not low at first wait");
  AST_PROG_SHORT: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_IDLE && HOLD_REQ_N && ACC_START && SW_WAIT_CNT < WS_MIN_ACTIVE
    |=> WAIT_STATES_DONE_OUT == PIN_IDLE)
    else $error("progress low with fewer than two waits");
  AST_PROG_RISE: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_SWWAIT && r_q.ws == WS_MIN_ACTIVE |=> WAIT_STATES_DONE_OUT == PIN_IDLE)
    else $error("progress not high at last wait");

  // Ready looked at only after the last software wait
  AST_READY_WAIT: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_READY && !READY |=> r_q.st == EBHW_READY)
    else $error("ready low not honoured");
  AST_NO_READY_SHORT: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_SWWAIT && r_q.ws == WS_ONE && r_q.ws_tot < WS_MIN_ACTIVE |=> r_q.st == EBHW_DONE)
    else $error("ready sampled with fewer than two waits");
  AST_TIED_ONE_WAIT: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_SWWAIT && r_q.ws == WS_ONE && ws_active(r_q.ws_tot)
    |=> r_q.st == EBHW_READY && WAIT_STATES_DONE_OUT == PIN_IDLE)
    else $error("no single ready wait after last internal wait");
  AST_ONE_EXTRA: assert property (@(posedge REF_CLK) disable iff (RST)
    r_q.st == EBHW_READY && READY |=> !ACC_DONE ##1 ACC_DONE)
    else $error("access not finished after ready");

  // Fetch indicator follows the access phase exactly
  AST_FETCH_IDLE: assert property (@(posedge REF_CLK) disable iff (RST)
    (r_q.st == EBHW_IDLE || r_q.st == EBHW_HOLD) |-> INSTR_FETCH_IND == PIN_IDLE)
    else $error("fetch indicator low with no address");
  AST_FETCH_ON: assert property (@(posedge REF_CLK) disable iff (RST)
    in_access(r_q.st) |-> INSTR_FETCH_IND == (r_q.fetch ? PIN_ACTIVE : PIN_IDLE))
    else $error("fetch indicator wrong during access");

  // Main scenarios worth seeing at least once
  COV_HOLD: cover property (@(posedge REF_CLK) disable iff (RST) r_q.st == EBHW_HOLD ##1 r_q.st == EBHW_IDLE);
  COV_READY_STALL: cover property (@(posedge REF_CLK) disable iff (RST) r_q.st == EBHW_READY && !READY);
  COV_FETCH: cover property (@(posedge REF_CLK) disable iff (RST) ACC_DONE && r_q.fetch);
  COV_OFF: cover property (@(posedge REF_CLK) disable iff (RST) !OUT_DISABLE_N ##1 !HOLD_GRANT_OE);
endmodule : ebhw_ctl
`default_nettype wire

/* File: hdl/ebhw_pkg.sv */
package ebhw_pkg;
  // Width of the software wait-state count
  localparam int WS_W = 3;
  // Least count for which the progress output and ready sampling act
  localparam logic [WS_W-1:0] WS_MIN_ACTIVE = 3'h2;
  localparam logic [WS_W-1:0] WS_ONE = 3'h1;
  localparam logic [WS_W-1:0] WS_ZERO = 3'h0;
  // Idle and active levels of the active-low bus outputs
  localparam logic PIN_IDLE = 1'h1;
  localparam logic PIN_ACTIVE = 1'h0;

  typedef enum logic [2:0] {
    EBHW_IDLE,
    EBHW_SWWAIT,
    EBHW_READY,
    EBHW_DONE,
    EBHW_HOLD
  } ebhw_state_t;
endpackage : ebhw_pkg

/* File: hdl/ebhw_outen.sv */
`timescale 1ns/1ps
`default_nettype none
// One pin's level and enable, both taken from registers
module ebhw_outen (
  input wire logic level,
  input wire logic oe_in,
  output logic pin_o,
  output logic pin_oe
);
  // No gate here: an inverter would keep the enable off a flop output
  assign pin_o = level;
  assign pin_oe = oe_in;
endmodule : ebhw_outen
`default_nettype wire

/* File: dv/ebhw_far.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side: memory with a ready line, plus a bus-requesting master
module ebhw_far (
  input wire logic tie_en,
  input wire logic stall,
  input wire logic want_bus,
  input wire logic progress_n,
  output logic ready,
  output logic hold_req_n
);
  // Board loop feeds progress back as ready; else a prompt or stalling device
  assign ready = tie_en ? progress_n : !stall;
  // Master asks for the bus with an active-low level
  assign hold_req_n = !want_bus;
endmodule : ebhw_far
`default_nettype wire

/* File: dv/tb_ext_bus_hold_waitstate_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ext_bus_hold_waitstate_ctl;
  import ebhw_pkg::*;
  logic clk, rst, want, odis_n, tie, stall, start, fetch, io, wr, ready, hreq_n;
  logic done, g, g_oe, p, p_oe, f, f_oe, ms, ios, rw, b_oe;
  logic [WS_W-1:0] cnt;
  int mismatches = 0;
  int comparisons = 0;
  ebhw_far i_ebhw_far (.tie_en(tie), .stall(stall), .want_bus(want), .progress_n(p), .ready(ready),
    .hold_req_n(hreq_n));
  ebhw_ctl i_ebhw_ctl (.REF_CLK(clk), .RST(rst), .HOLD_REQ_N(hreq_n), .OUT_DISABLE_N(odis_n),
    .READY(ready), .ACC_START(start), .ACC_IS_FETCH(fetch), .ACC_IS_IO(io), .ACC_WRITE(wr),
    .SW_WAIT_CNT(cnt), .ACC_DONE(done), .HOLD_GRANT_OUT(g), .HOLD_GRANT_OE(g_oe),
    .WAIT_STATES_DONE_OUT(p), .WAIT_STATES_DONE_OE(p_oe), .INSTR_FETCH_IND(f), .INSTR_FETCH_OE(f_oe),
    .MEM_STROBE_OUT(ms), .IO_STROBE_OUT(ios), .RW_OUT(rw), .BUS_CTL_OE(b_oe));
  // Shared compare; X never passes as a match
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // One access; s is how many ready checks the device refuses
  task automatic acc(input logic [WS_W-1:0] n, input logic fe, input logic i, input logic w, input int s);
    int k;
    int lat;
    @(posedge clk);
    #1;
    start = 1;
    cnt = n;
    fetch = fe;
    io = i;
    wr = w;
    stall = (s != 0);
    @(posedge clk);
    #1;
    start = 0;
    k = 0;
    // Address phase is out from the cycle after the start is taken
    chk("fetch_ind", {7'h0, !fe}, {7'h0, f});
    chk("strobes", {5'h0, !i, i, !w}, {5'h0, ios, ms, rw});
    if (n >= 2) chk("progress_first", 8'h0, {7'h0, p});
    while (done !== 1'h1) begin
      // Bounded wait so a hung access still reaches the report
      if (k == 20) begin
        $display("Error access_done expected 1 seen %0b", done);
        mismatches++;
        summarize();
      end
      @(posedge clk);
      #1;
      k++;
      if (n >= 3 && k == n - 2) chk("progress_mid", 8'h0, {7'h0, p});
      if (n >= 2 && k == n - 1) chk("progress_last", 8'h1, {7'h0, p});
      if (k == n + s) stall = 0;
    end
    // Ready costs its cycle only when two or more waits are programmed
    lat = (n >= 2) ? n + 2 + s : n + 1;
    chk("latency", 8'(lat), 8'(k));
    chk("bus_idle", 8'h0F, {4'h0, f, ios, ms, rw});
  endtask : acc
  // Hold request wins over a pending access and keeps the grant until withdrawn
  task automatic hold();
    @(posedge clk);
    #1;
    want = 1;
    start = 1;
    @(posedge clk);
    #1;
    chk("grant", 8'h0, {6'h0, g, b_oe});
    @(posedge clk);
    #1;
    start = 0;
    repeat (4) @(posedge clk);
    #1;
    chk("grant_held", 8'h1, {6'h0, g, f});
    want = 0;
    @(posedge clk);
    #1;
    chk("grant_release", 8'h3, {6'h0, g, b_oe});
  endtask : hold
  // Enables lag the disable input by one registered cycle
  task automatic off();
    odis_n = 0;
    repeat (2) @(posedge clk);
    #1;
    chk("off_oe", 8'h0, {4'h0, g_oe, p_oe, f_oe, b_oe});
    odis_n = 1;
    @(posedge clk);
    #1;
    chk("on_oe", 8'h0F, {4'h0, g_oe, p_oe, f_oe, b_oe});
  endtask : off
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1;
    want = 0;
    odis_n = 1;
    tie = 0;
    stall = 0;
    start = 0;
    fetch = 0;
    io = 0;
    wr = 0;
    cnt = 3'h0;
    repeat (12) @(posedge clk);
    #1;
    chk("reset_outs", 8'h3F, {2'h0, g, g_oe, p, p_oe, f, f_oe});
    rst = 0;
    acc(3'h0, 1, 0, 0, 0);
    acc(3'h1, 0, 1, 1, 0);
    tie = 1;
    acc(3'h2, 0, 0, 1, 0);
    acc(3'h7, 1, 0, 0, 0);
    tie = 0;
    acc(3'h3, 0, 1, 0, 3);
    hold();
    off();
    summarize();
  end
endmodule : tb_ext_bus_hold_waitstate_ctl
`default_nettype wire
